// [shared/dal_pkg.sv]
// constants, codes and types shared by the alu datapath files
package dal_pkg;
  localparam int unsigned WORD_W = 16;
  localparam int unsigned NUM_BANKS = 2;
  localparam int unsigned NUM_UREGS = 6;

  // unit register slots within one bank
  localparam logic [2:0] SLOT_XIN0 = 3'h0;
  localparam logic [2:0] SLOT_XIN1 = 3'h1;
  localparam logic [2:0] SLOT_YIN0 = 3'h2;
  localparam logic [2:0] SLOT_YIN1 = 3'h3;
  localparam logic [2:0] SLOT_FBK = 3'h4;
  localparam logic [2:0] SLOT_RES = 3'h5;

  // memory bus register select codes
  localparam logic [2:0] BUS_SEL_XIN0 = 3'h0;
  localparam logic [2:0] BUS_SEL_XIN1 = 3'h1;
  localparam logic [2:0] BUS_SEL_YIN0 = 3'h2;
  localparam logic [2:0] BUS_SEL_YIN1 = 3'h3;
  localparam logic [2:0] BUS_SEL_RES = 3'h4;

  // x operand source codes
  localparam logic [2:0] XSRC_XIN0 = 3'h0;
  localparam logic [2:0] XSRC_XIN1 = 3'h1;
  localparam logic [2:0] XSRC_RES = 3'h2;
  localparam logic [2:0] XSRC_MUL0 = 3'h3;
  localparam logic [2:0] XSRC_MUL1 = 3'h4;
  localparam logic [2:0] XSRC_MUL2 = 3'h5;
  localparam logic [2:0] XSRC_SHF0 = 3'h6;
  localparam logic [2:0] XSRC_SHF1 = 3'h7;

  // y operand source codes
  localparam logic [1:0] YSRC_YIN0 = 2'h0;
  localparam logic [1:0] YSRC_YIN1 = 2'h1;
  localparam logic [1:0] YSRC_FBK = 2'h2;

  // result destination codes
  localparam logic [1:0] DEST_NONE = 2'h0;
  localparam logic [1:0] DEST_RES = 2'h1;
  localparam logic [1:0] DEST_FBK = 2'h2;

  // arith status bit positions
  localparam int unsigned ST_ZERO = 0;
  localparam int unsigned ST_NEG = 1;
  localparam int unsigned ST_OVF = 2;
  localparam int unsigned ST_CARRY = 3;
  localparam int unsigned ST_XSIGN = 4;
  localparam int unsigned ST_QUOT = 5;
  localparam int unsigned ST_W = 6;
  localparam logic [5:0] ARITH_STATUS_RST = 6'h00;

  // mode status: bit 0 picks the register bank
  localparam int unsigned MODE_BANK_BIT = 0;
  localparam logic MODE_BANK_RST = 1'b0;

  // axi4-lite register byte offsets
  localparam logic [7:0] OFS_MODE_STATUS = 8'h00;
  localparam logic [7:0] OFS_ARITH_STATUS = 8'h04;
  localparam int unsigned AXI_ADDR_W = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [4:0] {
    OP_ADD    = 5'h00,
    OP_ADC    = 5'h01,
    OP_SUB_XY = 5'h02,
    OP_SBB_XY = 5'h03,
    OP_SUB_YX = 5'h04,
    OP_SBB_YX = 5'h05,
    OP_NEG_X  = 5'h06,
    OP_NEG_Y  = 5'h07,
    OP_INC_Y  = 5'h08,
    OP_DEC_Y  = 5'h09,
    OP_PASS_X = 5'h0a,
    OP_PASS_Y = 5'h0b,
    OP_CLR    = 5'h0c,
    OP_ABS_X  = 5'h0d,
    OP_AND    = 5'h0e,
    OP_OR     = 5'h0f,
    OP_XOR    = 5'h10,
    OP_NOT_X  = 5'h11,
    OP_NOT_Y  = 5'h12
  } dal_op_e;

  typedef logic [15:0] dal_word_t;
endpackage

// [logic/dal_alu_core.sv]
// combinational function core: result and flags for one operation
`timescale 1ns/10ps
module dal_alu_core (
  // operands
  input wire logic [15:0] x_in,
  input wire logic [15:0] y_in,
  input wire logic carry_in,
  input wire dal_pkg::dal_op_e op_in,
  // result and flags
  output logic [15:0] r_out,
  output logic zero_out,
  output logic neg_out,
  output logic carry_out,
  output logic ovf_out,
  output logic xsign_out
);
  logic [15:0] add_a;
  logic [15:0] add_b;
  logic add_c;
  logic use_adder;
  logic [16:0] sum;
  logic [15:0] logic_r;

  // every arithmetic op is folded onto one adder a + b + c
  always_comb begin
    add_a = x_in;
    add_b = y_in;
    add_c = 1'b0;
    use_adder = 1'b1;
    logic_r = 16'h0000;
    case (op_in)
      dal_pkg::OP_ADD: begin
        add_c = 1'b0;
      end
      dal_pkg::OP_ADC: begin
        add_c = carry_in;
      end
      dal_pkg::OP_SUB_XY: begin
        add_b = ~y_in;
        add_c = 1'b1;
      end
      dal_pkg::OP_SBB_XY: begin
        // x - y + c - 1 equals x + ~y + c
        add_b = ~y_in;
        add_c = carry_in;
      end
      dal_pkg::OP_SUB_YX: begin
        add_a = y_in;
        add_b = ~x_in;
        add_c = 1'b1;
      end
      dal_pkg::OP_SBB_YX: begin
        add_a = y_in;
        add_b = ~x_in;
        add_c = carry_in;
      end
      dal_pkg::OP_NEG_X: begin
        add_a = 16'h0000;
        add_b = ~x_in;
        add_c = 1'b1;
      end
      dal_pkg::OP_NEG_Y: begin
        add_a = 16'h0000;
        add_b = ~y_in;
        add_c = 1'b1;
      end
      dal_pkg::OP_INC_Y: begin
        add_a = 16'h0000;
        add_c = 1'b1;
      end
      dal_pkg::OP_DEC_Y: begin
        add_a = 16'hffff;
      end
      dal_pkg::OP_PASS_X: begin
        add_b = 16'h0000;
      end
      dal_pkg::OP_PASS_Y: begin
        add_a = 16'h0000;
      end
      dal_pkg::OP_CLR: begin
        add_a = 16'h0000;
        add_b = 16'h0000;
      end
      dal_pkg::OP_ABS_X: begin
        // negative x goes through the negate path, positive passes
        add_a = 16'h0000;
        add_b = x_in[15] ? ~x_in : x_in;
        add_c = x_in[15];
      end
      dal_pkg::OP_AND: begin
        use_adder = 1'b0;
        logic_r = x_in & y_in;
      end
      dal_pkg::OP_OR: begin
        use_adder = 1'b0;
        logic_r = x_in | y_in;
      end
      dal_pkg::OP_XOR: begin
        use_adder = 1'b0;
        logic_r = x_in ^ y_in;
      end
      dal_pkg::OP_NOT_X: begin
        use_adder = 1'b0;
        logic_r = ~x_in;
      end
      dal_pkg::OP_NOT_Y: begin
        use_adder = 1'b0;
        logic_r = ~y_in;
      end
      default: begin
        use_adder = 1'b0;
      end
    endcase
  end

  assign sum = {1'b0, add_a} + {1'b0, add_b} + {16'h0000, add_c};
  assign r_out = use_adder ? sum[15:0] : logic_r;
  assign zero_out = (r_out == 16'h0000);
  assign neg_out = r_out[15];
  // logic ops clear carry and overflow
  assign carry_out = use_adder & sum[16];
  assign ovf_out = use_adder & (add_a[15] == add_b[15]) & (sum[15] != add_a[15]);
  assign xsign_out = x_in[15];
endmodule

// [logic/dal_alu_datapath.sv]
// alu datapath top: banked unit registers, status, memory bus ports, axi4-lite
//
// How it works
// - sixteen-bit operands x, y and result r
// - carry-in comes from stored carry flag
// - six flags: zero, negative, carry, overflow, sign, quotient
// - flags latched into status at cycle end
// - x from own registers or result bus
// - x registers on data bus; program bus via exchange
// - x file feeds alu and data bus together
// - y from own registers or feedback register
// - y registers data bus read/write, program bus write
// - y file feeds alu and data bus together
// - result goes to feedback, result, or nowhere
// - result register drives buses, loads from data bus
// - read old value, write at cycle end
// - two full register banks, one active
// - mode bit zero picks primary or alternate
// - add, and add with carry
// - both subtractions, each with borrow form
// - negate either, increment and decrement y
// - pass x, pass y, clear, absolute x
// - and, or, xor, invert x or y
// - x also takes multiplier and shifter words
// - carry-in is the carry last latched by an operation or an axi write to arith status
// - overflow by twos-complement sign rules
// - carry is unsigned carry out of msb
`timescale 1ns/10ps
module dal_alu_datapath (
  // clock and reset
  input wire logic CLOCK,
  input wire logic SRST,
  // instruction from the sequencer
  input wire logic OP_VALID,
  input wire dal_pkg::dal_op_e OP_CODE,
  input wire logic [2:0] X_SEL,
  input wire logic [1:0] Y_SEL,
  input wire logic [1:0] DEST_SEL,
  // other units' result words on the result bus
  input wire logic [15:0] MULT_RESULT_WORD0,
  input wire logic [15:0] MULT_RESULT_WORD1,
  input wire logic [15:0] MULT_RESULT_WORD2,
  input wire logic [15:0] SHIFT_RESULT_WORD0,
  input wire logic [15:0] SHIFT_RESULT_WORD1,
  output logic [15:0] RESULT_BUS_OUT,
  // data memory bus
  input wire logic DBUS_WR_EN,
  input wire logic [2:0] DBUS_WR_SEL,
  input wire logic [15:0] DBUS_WR_DATA,
  input wire logic DBUS_RD_EN,
  input wire logic [2:0] DBUS_RD_SEL,
  output logic [15:0] DBUS_RD_DATA,
  // program memory bus, writes only
  input wire logic PBUS_WR_EN,
  input wire logic PBUS_WR_SEL,
  input wire logic [15:0] PBUS_WR_DATA,
  // flags
  output logic ZERO_FLAG,
  output logic NEGATIVE_FLAG,
  output logic CARRY_FLAG,
  output logic OVERFLOW_FLAG,
  output logic X_SIGN_FLAG,
  output logic QUOTIENT_FLAG,
  output logic BANK_SEL,
  // axi4-lite slave
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);
  typedef struct packed {
    logic [1:0][5:0][15:0] uregs;
    logic [5:0] arith_status;
    logic mode_bank;
    logic [15:0] dmd_rd_data;
    logic aw_got;
    logic [7:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } dal_state_s;

  dal_state_s st_r;
  dal_state_s st_nxt;

  logic [15:0] x_opnd;
  logic [15:0] y_opnd;
  logic [15:0] alu_r;
  logic f_zero;
  logic f_neg;
  logic f_carry;
  logic f_ovf;
  logic f_xsign;
  logic bank;
  logic [5:0][15:0] cur;

  // maps a memory bus select code to a slot; flags codes with no register
  function automatic logic [3:0] bus_slot(input logic [2:0] sel);
    logic [3:0] res;
    res = {1'b0, dal_pkg::SLOT_XIN0};
    if (sel == dal_pkg::BUS_SEL_XIN0) begin
      res = {1'b1, dal_pkg::SLOT_XIN0};
    end else if (sel == dal_pkg::BUS_SEL_XIN1) begin
      res = {1'b1, dal_pkg::SLOT_XIN1};
    end else if (sel == dal_pkg::BUS_SEL_YIN0) begin
      res = {1'b1, dal_pkg::SLOT_YIN0};
    end else if (sel == dal_pkg::BUS_SEL_YIN1) begin
      res = {1'b1, dal_pkg::SLOT_YIN1};
    end else if (sel == dal_pkg::BUS_SEL_RES) begin
      res = {1'b1, dal_pkg::SLOT_RES};
    end
    return res;
  endfunction

  // only the bank named by the mode bit is read or written, except that reset clears both
  assign bank = st_r.mode_bank;
  assign cur = st_r.uregs[bank];

  // x port: own file, result register, multiplier and shifter words
  always_comb begin
    case (X_SEL)
      dal_pkg::XSRC_XIN0: begin
        x_opnd = cur[dal_pkg::SLOT_XIN0];
      end
      dal_pkg::XSRC_XIN1: begin
        x_opnd = cur[dal_pkg::SLOT_XIN1];
      end
      dal_pkg::XSRC_RES: begin
        x_opnd = cur[dal_pkg::SLOT_RES];
      end
      dal_pkg::XSRC_MUL0: begin
        x_opnd = MULT_RESULT_WORD0;
      end
      dal_pkg::XSRC_MUL1: begin
        x_opnd = MULT_RESULT_WORD1;
      end
      dal_pkg::XSRC_MUL2: begin
        x_opnd = MULT_RESULT_WORD2;
      end
      dal_pkg::XSRC_SHF0: begin
        x_opnd = SHIFT_RESULT_WORD0;
      end
      default: begin
        x_opnd = SHIFT_RESULT_WORD1;
      end
    endcase
  end

  // y port: own file or feedback; unused code reads as feedback
  always_comb begin
    case (Y_SEL)
      dal_pkg::YSRC_YIN0: begin
        y_opnd = cur[dal_pkg::SLOT_YIN0];
      end
      dal_pkg::YSRC_YIN1: begin
        y_opnd = cur[dal_pkg::SLOT_YIN1];
      end
      default: begin
        y_opnd = cur[dal_pkg::SLOT_FBK];
      end
    endcase
  end

  dal_alu_core u_core (
    .x_in(x_opnd),
    .y_in(y_opnd),
    .carry_in(st_r.arith_status[dal_pkg::ST_CARRY]),
    .op_in(OP_CODE),
    .r_out(alu_r),
    .zero_out(f_zero),
    .neg_out(f_neg),
    .carry_out(f_carry),
    .ovf_out(f_ovf),
    .xsign_out(f_xsign)
  );

  always_comb begin
    logic [3:0] wslot;
    logic [3:0] rslot;
    logic [7:0] ra;
    logic aw_now;
    logic w_now;
    wslot = bus_slot(DBUS_WR_SEL);
    rslot = bus_slot(DBUS_RD_SEL);
    ra = S_AXI_ARADDR;
    aw_now = 1'b0;
    w_now = 1'b0;
    st_nxt = st_r;

    // bus writes land at the cycle end; operand reads used the old value
    if (DBUS_WR_EN && wslot[3]) begin
      st_nxt.uregs[bank][wslot[2:0]] = DBUS_WR_DATA;
    end
    if (PBUS_WR_EN) begin
      if (PBUS_WR_SEL) begin
        st_nxt.uregs[bank][dal_pkg::SLOT_YIN1] = PBUS_WR_DATA;
      end else begin
        st_nxt.uregs[bank][dal_pkg::SLOT_YIN0] = PBUS_WR_DATA;
      end
    end

    // a program bus read is served by the exchange unit through this port
    if (DBUS_RD_EN) begin
      if (rslot[3]) begin
        st_nxt.dmd_rd_data = cur[rslot[2:0]];
      end else begin
        st_nxt.dmd_rd_data = 16'h0000;
      end
    end

    // axi write channel: address and data may arrive in either order
    if (S_AXI_AWVALID && !st_r.aw_got && !st_r.bvalid) begin
      st_nxt.aw_got = 1'b1;
      st_nxt.aw_addr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && !st_r.w_got && !st_r.bvalid) begin
      st_nxt.w_got = 1'b1;
      st_nxt.w_data = S_AXI_WDATA;
      st_nxt.w_strb = S_AXI_WSTRB;
    end
    aw_now = st_r.aw_got;
    w_now = st_r.w_got;
    if (aw_now && w_now && !st_r.bvalid) begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = dal_pkg::RESP_OKAY;
      if (st_r.aw_addr[7:2] == dal_pkg::OFS_MODE_STATUS[7:2]) begin
        if (st_r.w_strb[0]) begin
          st_nxt.mode_bank = st_r.w_data[dal_pkg::MODE_BANK_BIT];
        end
      end else if (st_r.aw_addr[7:2] == dal_pkg::OFS_ARITH_STATUS[7:2]) begin
        if (st_r.w_strb[0]) begin
          st_nxt.arith_status = st_r.w_data[dal_pkg::ST_W-1:0];
        end
      end else begin
        st_nxt.bresp = dal_pkg::RESP_SLVERR;
      end
    end
    if (st_r.bvalid && S_AXI_BREADY) begin
      st_nxt.bvalid = 1'b0;
    end

    // axi read channel: one read outstanding, answered the next cycle
    if (S_AXI_ARVALID && !st_r.rvalid) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp = dal_pkg::RESP_OKAY;
      st_nxt.rdata = 32'h00000000;
      if (ra[7:2] == dal_pkg::OFS_MODE_STATUS[7:2]) begin
        st_nxt.rdata[dal_pkg::MODE_BANK_BIT] = st_r.mode_bank;
      end else if (ra[7:2] == dal_pkg::OFS_ARITH_STATUS[7:2]) begin
        st_nxt.rdata[dal_pkg::ST_W-1:0] = st_r.arith_status;
      end else begin
        st_nxt.rresp = dal_pkg::RESP_SLVERR;
      end
    end else if (st_r.rvalid && S_AXI_RREADY) begin
      st_nxt.rvalid = 1'b0;
    end

    // the operation comes after the bus and axi writes so its result and flags win over them; only reset follows
    if (OP_VALID) begin
      if (DEST_SEL == dal_pkg::DEST_RES) begin
        st_nxt.uregs[bank][dal_pkg::SLOT_RES] = alu_r;
      end else if (DEST_SEL == dal_pkg::DEST_FBK) begin
        st_nxt.uregs[bank][dal_pkg::SLOT_FBK] = alu_r;
      end
      // flags latch even when the result is discarded
      st_nxt.arith_status[dal_pkg::ST_ZERO] = f_zero;
      st_nxt.arith_status[dal_pkg::ST_NEG] = f_neg;
      st_nxt.arith_status[dal_pkg::ST_CARRY] = f_carry;
      st_nxt.arith_status[dal_pkg::ST_OVF] = f_ovf;
      st_nxt.arith_status[dal_pkg::ST_XSIGN] = f_xsign;
      // quotient flag holds on an operation; only an axi write to arith status or reset moves it here
      st_nxt.arith_status[dal_pkg::ST_QUOT] = st_r.arith_status[dal_pkg::ST_QUOT];
    end

    if (SRST) begin
      st_nxt = '0;
      st_nxt.arith_status = dal_pkg::ARITH_STATUS_RST;
      st_nxt.mode_bank = dal_pkg::MODE_BANK_RST;
    end
  end

  always_ff @(posedge CLOCK) begin
    st_r <= st_nxt;
  end

  // handshake outputs are combinational from state
  assign S_AXI_AWREADY = !st_r.aw_got && !st_r.bvalid;
  assign S_AXI_WREADY = !st_r.w_got && !st_r.bvalid;
  assign S_AXI_ARREADY = !st_r.rvalid;
  assign S_AXI_BVALID = st_r.bvalid;
  assign S_AXI_BRESP = st_r.bresp;
  assign S_AXI_RVALID = st_r.rvalid;
  assign S_AXI_RRESP = st_r.rresp;
  assign S_AXI_RDATA = st_r.rdata;

  assign RESULT_BUS_OUT = cur[dal_pkg::SLOT_RES];
  assign DBUS_RD_DATA = st_r.dmd_rd_data;
  assign ZERO_FLAG = st_r.arith_status[dal_pkg::ST_ZERO];
  assign NEGATIVE_FLAG = st_r.arith_status[dal_pkg::ST_NEG];
  assign CARRY_FLAG = st_r.arith_status[dal_pkg::ST_CARRY];
  assign OVERFLOW_FLAG = st_r.arith_status[dal_pkg::ST_OVF];
  assign X_SIGN_FLAG = st_r.arith_status[dal_pkg::ST_XSIGN];
  assign QUOTIENT_FLAG = st_r.arith_status[dal_pkg::ST_QUOT];
  assign BANK_SEL = st_r.mode_bank;
endmodule

// [verification/dal_alu_datapath_sva.sv]
// port checker for the alu datapath
`timescale 1ns/10ps
module dal_alu_datapath_sva (
  // clock and reset
  input wire logic CLOCK,
  input wire logic SRST,
  // instruction and operands
  input wire logic OP_VALID,
  input wire dal_pkg::dal_op_e OP_CODE,
  input wire logic [2:0] X_SEL,
  input wire logic [1:0] DEST_SEL,
  input wire logic [15:0] MULT_RESULT_WORD0,
  input wire logic [15:0] SHIFT_RESULT_WORD1,
  input wire logic [15:0] RESULT_BUS_OUT,
  // data bus read
  input wire logic DBUS_RD_EN,
  input wire logic [2:0] DBUS_RD_SEL,
  input wire logic [15:0] DBUS_RD_DATA,
  // flags and bus response
  input wire logic ZERO_FLAG,
  input wire logic NEGATIVE_FLAG,
  input wire logic CARRY_FLAG,
  input wire logic OVERFLOW_FLAG,
  input wire logic X_SIGN_FLAG,
  input wire logic QUOTIENT_FLAG,
  input wire logic S_AXI_BVALID
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (SRST);
  logic ar_op, sr1_msb;
  logic [5:0] flags;
  assign ar_op = OP_VALID && DEST_SEL == dal_pkg::DEST_RES;
  assign sr1_msb = SHIFT_RESULT_WORD1[15];
  assign flags = {ZERO_FLAG, NEGATIVE_FLAG, CARRY_FLAG, OVERFLOW_FLAG, X_SIGN_FLAG, QUOTIENT_FLAG};
  // a software write lands with bvalid, so those cycles are excused
  property p_zero; ar_op |=> S_AXI_BVALID || ZERO_FLAG == (RESULT_BUS_OUT == 16'h0); endproperty
  a_zero: assert property (p_zero)
    else $error("zero flag disagrees with result");
  property p_neg; ar_op |=> S_AXI_BVALID || NEGATIVE_FLAG == RESULT_BUS_OUT[15]; endproperty
  a_neg: assert property (p_neg)
    else $error("negative flag disagrees with result");
  property p_clr; OP_VALID && OP_CODE == dal_pkg::OP_CLR |=> ZERO_FLAG && !CARRY_FLAG && !OVERFLOW_FLAG; endproperty
  a_clr: assert property (p_clr)
    else $error("clear left wrong flags");
  property p_mr;
    ar_op && OP_CODE == dal_pkg::OP_PASS_X && X_SEL == dal_pkg::XSRC_MUL0
      |=> S_AXI_BVALID || RESULT_BUS_OUT == $past(MULT_RESULT_WORD0);
  endproperty
  a_mr: assert property (p_mr)
    else $error("multiplier word not passed");
  property p_xs; OP_VALID && X_SEL == dal_pkg::XSRC_SHF1 |=> X_SIGN_FLAG == $past(sr1_msb); endproperty
  a_xs: assert property (p_xs)
    else $error("x sign flag wrong");
  property p_quot; OP_VALID |=> S_AXI_BVALID || $stable(QUOTIENT_FLAG); endproperty
  a_quot: assert property (p_quot)
    else $error("quotient flag moved on an op");
  property p_hold; !OP_VALID |=> S_AXI_BVALID || $stable(flags); endproperty
  a_hold: assert property (p_hold)
    else $error("flags moved without an op");
  property p_rdar; DBUS_RD_EN && DBUS_RD_SEL == dal_pkg::BUS_SEL_RES |=> DBUS_RD_DATA == $past(RESULT_BUS_OUT); endproperty
  a_rdar: assert property (p_rdar)
    else $error("result register read wrong");
  property p_rdhold; !DBUS_RD_EN |=> $stable(DBUS_RD_DATA); endproperty
  a_rdhold: assert property (p_rdhold)
    else $error("read data moved without a read");
  c_adc: cover property (ar_op && OP_CODE == dal_pkg::OP_ADC);
  c_axi: cover property (S_AXI_BVALID);
  c_rd: cover property (DBUS_RD_EN && DBUS_RD_SEL == dal_pkg::BUS_SEL_RES);
endmodule
bind dal_alu_datapath dal_alu_datapath_sva chk_u (.*);

// [verification/dal_far_model.sv]
// far-side model: multiplier and shifter result words
`timescale 1ns/10ps
module dal_far_model (
  // clock and reset
  input wire logic CLOCK,
  input wire logic SRST,
  // result bus words
  output logic [15:0] MULT_RESULT_WORD0,
  output logic [15:0] MULT_RESULT_WORD1,
  output logic [15:0] MULT_RESULT_WORD2,
  output logic [15:0] SHIFT_RESULT_WORD0,
  output logic [15:0] SHIFT_RESULT_WORD1
);
  logic [15:0] lfsr_r;
  // words change every cycle so a late or early operand pick shows up
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      lfsr_r <= 16'hace1;
    end else begin
      lfsr_r <= {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
    end
  end
  assign MULT_RESULT_WORD0 = lfsr_r;
  assign MULT_RESULT_WORD1 = ~lfsr_r;
  assign MULT_RESULT_WORD2 = {lfsr_r[7:0], lfsr_r[15:8]};
  assign SHIFT_RESULT_WORD0 = lfsr_r ^ 16'h8000;
  assign SHIFT_RESULT_WORD1 = lfsr_r + 16'h1234;
endmodule

// [verification/dal_alu_datapath_tb.sv]
// self-checking testbench for the alu datapath
`timescale 1ns/10ps
module dal_alu_datapath_tb;
  logic CLOCK = 1'b0, SRST = 1'b1, OP_VALID = 1'b0;
  dal_pkg::dal_op_e OP_CODE = dal_pkg::OP_ADD;
  logic [2:0] X_SEL = 3'h0, DBUS_WR_SEL = 3'h0, DBUS_RD_SEL = 3'h0;
  logic [1:0] Y_SEL = 2'h0, DEST_SEL = 2'h0, S_AXI_BRESP, S_AXI_RRESP;
  logic [15:0] MULT_RESULT_WORD0, MULT_RESULT_WORD1, MULT_RESULT_WORD2, SHIFT_RESULT_WORD0, SHIFT_RESULT_WORD1;
  logic [15:0] RESULT_BUS_OUT, DBUS_RD_DATA, DBUS_WR_DATA = 16'h0, PBUS_WR_DATA = 16'h0;
  logic DBUS_WR_EN = 1'b0, DBUS_RD_EN = 1'b0, PBUS_WR_EN = 1'b0, PBUS_WR_SEL = 1'b0;
  logic ZERO_FLAG, NEGATIVE_FLAG, CARRY_FLAG, OVERFLOW_FLAG, X_SIGN_FLAG, QUOTIENT_FLAG, BANK_SEL;
  logic [7:0] S_AXI_AWADDR = 8'h0, S_AXI_ARADDR = 8'h0;
  logic S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0, S_AXI_BREADY = 1'b0, S_AXI_ARVALID = 1'b0, S_AXI_RREADY = 1'b0;
  logic [31:0] S_AXI_WDATA = 32'h0, S_AXI_RDATA;
  logic [3:0] S_AXI_WSTRB = 4'h0;
  logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
  int failures = 0, checks_done = 0, cycles = 0, seed = 34979;
  // reference copy of both banks: slots x0 x1 y0 y1 feedback result
  logic [15:0] m[2][6];
  logic bk, cy, qf;
  dal_alu_datapath dut_u (.*);
  dal_far_model far_u (.*);
  always #5 CLOCK = ~CLOCK;
  always @(posedge CLOCK) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      tally_and_finish;
    end
  end
  task tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  // returns {carry, overflow, result}
  function automatic logic [17:0] alu(input logic [4:0] o, input logic [15:0] x, input logic [15:0] y, input logic c);
    logic [15:0] a, b, r;
    logic ci;
    logic [16:0] s;
    a = x;
    b = y;
    ci = 1'b0;
    case (o)
      5'h01: ci = c;
      5'h02: begin b = ~y; ci = 1'b1; end
      5'h03: begin b = ~y; ci = c; end
      5'h04: begin a = ~x; ci = 1'b1; end
      5'h05: begin a = ~x; ci = c; end
      5'h06: begin a = 16'h0; b = ~x; ci = 1'b1; end
      5'h07: begin a = 16'h0; b = ~y; ci = 1'b1; end
      5'h08: begin a = 16'h0; ci = 1'b1; end
      5'h09: a = 16'hffff;
      5'h0a: b = 16'h0;
      5'h0b: a = 16'h0;
      5'h0c: begin a = 16'h0; b = 16'h0; end
      5'h0d: begin a = 16'h0; b = x[15] ? ~x : x; ci = x[15]; end
      default: ;
    endcase
    s = {1'b0, a} + {1'b0, b} + {16'h0, ci};
    r = s[15:0];
    case (o)
      5'h0e: r = x & y;
      5'h0f: r = x | y;
      5'h10: r = x ^ y;
      5'h11: r = ~x;
      5'h12: r = ~y;
      default: ;
    endcase
    if (o > 5'h0d) return {2'b00, r};
    return {s[16], a[15] == b[15] && s[15] != a[15], r};
  endfunction
  function automatic logic [15:0] xv(input logic [2:0] s);
    case (s)
      3'h0: return m[bk][0];
      3'h1: return m[bk][1];
      3'h2: return m[bk][5];
      3'h3: return MULT_RESULT_WORD0;
      3'h4: return MULT_RESULT_WORD1;
      3'h5: return MULT_RESULT_WORD2;
      3'h6: return SHIFT_RESULT_WORD0;
      default: return SHIFT_RESULT_WORD1;
    endcase
  endfunction
  task op(input logic [4:0] o, input logic [2:0] xs, input logic [1:0] ys, input logic [1:0] ds);
    logic [15:0] x;
    logic [17:0] q;
    @(posedge CLOCK);
    OP_VALID <= 1'b1;
    OP_CODE <= dal_pkg::dal_op_e'(o);
    X_SEL <= xs;
    Y_SEL <= ys;
    DEST_SEL <= ds;
    #1;
    x = xv(xs);
    q = alu(o, x, ys[1] ? m[bk][4] : m[bk][2 + ys], cy);
    @(posedge CLOCK);
    OP_VALID <= 1'b0;
    if (ds == 2'h1) m[bk][5] = q[15:0];
    if (ds == 2'h2) m[bk][4] = q[15:0];
    cy = q[17];
    #1;
    chk("flags", {ZERO_FLAG, NEGATIVE_FLAG, CARRY_FLAG, OVERFLOW_FLAG, X_SIGN_FLAG, QUOTIENT_FLAG},
        {q[15:0] == 16'h0, q[15], q[17], q[16], x[15], qf});
    chk("result", RESULT_BUS_OUT, m[bk][5]);
  endtask
  // write and read one register in the same cycle: the read sees the old value
  task dw(input logic [2:0] s, input logic [15:0] d);
    int k;
    k = (s == 3'h4) ? 5 : s;
    @(posedge CLOCK);
    DBUS_WR_EN <= 1'b1;
    DBUS_WR_SEL <= s;
    DBUS_WR_DATA <= d;
    DBUS_RD_EN <= 1'b1;
    DBUS_RD_SEL <= s;
    @(posedge CLOCK);
    DBUS_WR_EN <= 1'b0;
    DBUS_RD_EN <= 1'b0;
    #1;
    chk("bus read", DBUS_RD_DATA, s > 3'h4 ? 16'h0 : m[bk][k]);
    if (s <= 3'h4) m[bk][k] = d;
  endtask
  task pw(input logic s, input logic [15:0] d);
    @(posedge CLOCK);
    PBUS_WR_EN <= 1'b1;
    PBUS_WR_SEL <= s;
    PBUS_WR_DATA <= d;
    @(posedge CLOCK);
    PBUS_WR_EN <= 1'b0;
    m[bk][2 + s] = d;
  endtask
  task aw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge CLOCK);
    S_AXI_AWADDR <= a;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WDATA <= d;
    S_AXI_WSTRB <= 4'hf;
    S_AXI_WVALID <= 1'b1;
    S_AXI_BREADY <= 1'b1;
    do begin
      @(posedge CLOCK);
      if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
      if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
    end while (S_AXI_BVALID !== 1'b1);
    S_AXI_BREADY <= 1'b0;
    chk("bresp", S_AXI_BRESP, er);
  endtask
  task ar(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge CLOCK);
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY <= 1'b1;
    do begin
      @(posedge CLOCK);
      if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
    end while (S_AXI_RVALID !== 1'b1);
    S_AXI_RREADY <= 1'b0;
    chk("rdata", S_AXI_RDATA, e);
    chk("rresp", S_AXI_RRESP, er);
  endtask
  initial begin
    bk = 1'b0;
    cy = 1'b0;
    qf = 1'b0;
    foreach (m[i, j]) m[i][j] = 16'h0;
    repeat (2) @(posedge CLOCK);
    SRST <= 1'b0;
    @(posedge CLOCK);
    #1;
    chk("reset", {ZERO_FLAG, CARRY_FLAG, QUOTIENT_FLAG, BANK_SEL, RESULT_BUS_OUT}, 32'h0);
    ar(dal_pkg::OFS_ARITH_STATUS, 32'h0, dal_pkg::RESP_OKAY);
    ar(8'h10, 32'h0, dal_pkg::RESP_SLVERR);
    dw(3'h0, 16'hffff);
    dw(3'h2, 16'h0001);
    dw(3'h1, 16'h7fff);
    dw(3'h3, 16'h0000);
    op(5'h00, 3'h0, 2'h0, 2'h1);
    op(5'h01, 3'h1, 2'h1, 2'h1);
    op(5'h03, 3'h1, 2'h1, 2'h2);
    dw(3'h0, 16'h8000);
    op(5'h0d, 3'h0, 2'h0, 2'h1);
    op(5'h06, 3'h0, 2'h0, 2'h2);
    op(5'h0a, 3'h3, 2'h0, 2'h1);
    op(5'h0b, 3'h0, 2'h2, 2'h1);
    aw(dal_pkg::OFS_ARITH_STATUS, 32'h28, dal_pkg::RESP_OKAY);
    qf = 1'b1;
    cy = 1'b1;
    ar(dal_pkg::OFS_ARITH_STATUS, 32'h28, dal_pkg::RESP_OKAY);
    op(5'h01, 3'h1, 2'h1, 2'h1);
    for (int b = 0; b < 2; b++) begin
      aw(dal_pkg::OFS_MODE_STATUS, 32'(b), dal_pkg::RESP_OKAY);
      bk = 1'(b);
      ar(dal_pkg::OFS_MODE_STATUS, 32'(b), dal_pkg::RESP_OKAY);
      chk("bank", BANK_SEL, bk);
      // random fill and every function code at least twice per bank
      for (int i = 0; i < 40; i++) begin
        dw(3'($random(seed)), 16'($random(seed)));
        pw(1'($random(seed)), 16'($random(seed)));
        op(5'(i % 19), 3'($random(seed)), 2'($random(seed)), 2'($random(seed)));
      end
    end
    aw(dal_pkg::OFS_MODE_STATUS, 32'h0, dal_pkg::RESP_OKAY);
    bk = 1'b0;
    for (int s = 0; s < 5; s++) dw(3'(s), 16'h0);
    tally_and_finish;
  end
endmodule
